/* dctm_defs.svh */
// Constants for the dual counter/timer: APB offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by the top design file and the testbench only.
`ifndef DCTM_DEFS_SVH
`define DCTM_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DCTM_OFS_A_LOW 12'h000
`define DCTM_OFS_A_HIGH 12'h004
`define DCTM_OFS_B_LOW 12'h008
`define DCTM_OFS_B_HIGH 12'h00C
`define DCTM_OFS_CTRL 12'h010
`define DCTM_OFS_MODE 12'h014
`define DCTM_OFS_CLKSEL 12'h018
`define DCTM_OFS_EXTCFG 12'h01C
`define DCTM_OFS_IRQEN 12'h020
`define DCTM_OFS_IRQCLR 12'h024

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCTM_CTRL_RUN_A 4
`define DCTM_CTRL_OVF_A 5
`define DCTM_CTRL_RUN_B 6
`define DCTM_CTRL_OVF_B 7
`define DCTM_MODE_A_LSB 0
`define DCTM_MODE_GATE_A 3
`define DCTM_MODE_CSEL_A 2
`define DCTM_MODE_B_LSB 4
`define DCTM_MODE_CSEL_B 6
`define DCTM_MODE_GATE_B 7
`define DCTM_CLK_SCA_LSB 0
`define DCTM_CLK_SYS_A 3
`define DCTM_CLK_SYS_B 4
`define DCTM_EXT_POL_A 3
`define DCTM_EXT_POL_B 7
`define DCTM_IRQ_A 0
`define DCTM_IRQ_B 1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DCTM_RST_BYTE 8'h00
`define DCTM_MAX13 13'h1FFF
`define DCTM_DIV4 6'd4
`define DCTM_DIV12 6'd12
`define DCTM_DIV48 6'd48

`endif

/* dctm_pkg.sv */
// Types shared by the dual counter/timer design.
// Assumes dctm_defs.svh holds all numeric constants.
package dctm_pkg;
    typedef enum logic [1:0] {
        DCTM_MODE13,
        DCTM_MODE16,
        DCTM_MODE8RL,
        DCTM_MODESPLIT
    } dctm_mode_t;
    typedef logic [15:0] dctm_count_t;
endpackage : dctm_pkg

/* dctm_edge_sync.sv */
// Two-flop synchroniser with falling-edge pulse.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/10ps
module dctm_edge_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pinIn,
    output logic syncOut,
    output logic fallPulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pinIn;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign syncOut = sync_r;
    // Two successive samples compared, one-cycle enable
    assign fallPulse = prev_r & ~sync_r;
endmodule : dctm_edge_sync

/* dctm_top.sv */
// Dual 16-bit counter/timer with APB register access.
// Assumes an APB master on core_clk; pins are asynchronous.
//
// Summary of operation
// - Counter function increments on each falling edge of the count pin.
// - Events up to a quarter of the system clock are counted.
// - Count is 16 bits, accessed as separate low and high bytes.
// - Each timer has its own independent two-bit mode field.
// - 13-bit mode: high byte is top eight bits, low bits 4..0 bottom.
// - 13-bit wrap from all ones sets overflow flag, may interrupt.
// - Counter-select 1 takes pin edges, 0 takes the internal clock.
// - Sysclk-select 1 uses system clock, 0 uses prescaled clock.
// - Five clock sources via sysclk-select and shared prescale field.
// - Count only with run set and gate off or gate input active; split high byte needs run B only.
// - Setting run resumes from the held value, never clears it.
// - Timer B mirrors A with own bits and second gate polarity.
// - Overflow interrupts only when that timer's enable bit is set.
// - Mode codes: 13-bit, 16-bit, 8-bit reload, split 8-bit (A only).
// - Flag set by hardware, cleared by software or vector acknowledge.
`timescale 1ns/10ps
`include "dctm_defs.svh"
module dctm_top (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timerACountPin,
    input wire logic timerBCountPin,
    input wire logic extGateInput,
    input wire logic irqAckA,
    input wire logic irqAckB,
    output logic irqOut
);
    import dctm_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    dctm_count_t cntA_r, cntB_r;
    logic [7:0] ctrl_r, modeReg_r, clkSel_r, extCfg_r, irqEn_r;
    logic [5:0] preCnt_r;
    logic preTick_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, irq_r;
    logic gateMeta_r, gateSync_r;

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic pinAFall, pinBFall;

    dctm_edge_sync uSyncA (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(timerACountPin),
        .syncOut(),
        .fallPulse(pinAFall)
    );

    dctm_edge_sync uSyncB (
        .core_clk(core_clk),
        .reset(reset),
        .pinIn(timerBCountPin),
        .syncOut(),
        .fallPulse(pinBFall)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            gateMeta_r <= 1'b0;
            gateSync_r <= 1'b0;
        end else begin
            gateMeta_r <= extGateInput;
            gateSync_r <= gateMeta_r;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler: one-cycle tick at the selected division
    // ----------------------------------------------------------------
    logic [1:0] scaSel;
    logic [5:0] preDiv;
    logic preWrap;
    assign scaSel = clkSel_r[`DCTM_CLK_SCA_LSB +: 2];
    // Divide by 12, 4, 48; code 3 uses the pin B edges as a slow source
    assign preDiv = (scaSel == 2'd0) ? 6'(`DCTM_DIV12) :
                    (scaSel == 2'd1) ? 6'(`DCTM_DIV4) :
                    6'(`DCTM_DIV48);
    assign preWrap = (preCnt_r >= preDiv - 6'd1);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            preCnt_r <= 6'd0;
            preTick_r <= 1'b0;
        end else begin
            preCnt_r <= preWrap ? 6'd0 : preCnt_r + 6'd1;
            preTick_r <= preWrap;
        end
    end

    // Fifth source: code 3 counts synchronised pin-B edges
    logic preClk;
    assign preClk = (scaSel == 2'd3) ? pinBFall : preTick_r;

    // ----------------------------------------------------------------
    // Count enables
    // ----------------------------------------------------------------
    function automatic logic tickSel(input logic csel, input logic sysSel,
                                     input logic pinFall, input logic pre);
        // Pin edge, system clock or prescaled clock
        tickSel = csel ? pinFall : (sysSel ? 1'b1 : pre);
    endfunction : tickSel

    function automatic logic runOk(input logic run, input logic gate,
                                   input logic lvl, input logic pol);
        runOk = run & (~gate | (lvl == pol));
    endfunction : runOk

    dctm_mode_t modeA, modeB;
    assign modeA = dctm_mode_t'(modeReg_r[`DCTM_MODE_A_LSB +: 2]);
    assign modeB = dctm_mode_t'(modeReg_r[`DCTM_MODE_B_LSB +: 2]);

    logic tickA, tickB, tickAH, enA, enB, enAH;
    assign tickA = tickSel(modeReg_r[`DCTM_MODE_CSEL_A],
                           clkSel_r[`DCTM_CLK_SYS_A], pinAFall, preClk);
    // Timer B with its own bits, second polarity
    assign tickB = tickSel(modeReg_r[`DCTM_MODE_CSEL_B],
                           clkSel_r[`DCTM_CLK_SYS_B], pinBFall, preClk);
    // Split-mode high byte: internal clock only
    assign tickAH = clkSel_r[`DCTM_CLK_SYS_A] ? 1'b1 : preClk;
    assign enA = tickA & runOk(ctrl_r[`DCTM_CTRL_RUN_A],
                               modeReg_r[`DCTM_MODE_GATE_A], gateSync_r,
                               extCfg_r[`DCTM_EXT_POL_A]);
    assign enB = tickB & (modeA != DCTM_MODESPLIT)
               & (modeB != DCTM_MODESPLIT)
               & runOk(ctrl_r[`DCTM_CTRL_RUN_B],
                       modeReg_r[`DCTM_MODE_GATE_B], gateSync_r,
                       extCfg_r[`DCTM_EXT_POL_B]);
    assign enAH = tickAH & ctrl_r[`DCTM_CTRL_RUN_B];

    // ----------------------------------------------------------------
    // Counter next values and overflow
    // ----------------------------------------------------------------
    function automatic logic [16:0] stepCnt(input dctm_mode_t m,
                                            input dctm_count_t c);
        logic [12:0] c13;
        logic [8:0] c8;
        c13 = 13'(c[7:0] & 8'h1F) | (13'(c[15:8]) << 5);
        c8 = 9'(c[7:0]) + 9'd1;
        stepCnt = 17'h00000;
        case (m)
            DCTM_MODE13: begin
                // Only low five bits of low byte advance
                stepCnt[15:0] = {8'((c13 + 13'd1) >> 5), c[7:5],
                                 5'((c13 + 13'd1) & 13'h001F)};
                stepCnt[16] = (c13 == `DCTM_MAX13);
            end
            DCTM_MODE16: begin
                stepCnt = 17'(c) + 17'd1;
            end
            DCTM_MODE8RL: begin
                stepCnt[15:8] = c[15:8];
                stepCnt[7:0] = c8[8] ? c[15:8] : c8[7:0];
                stepCnt[16] = c8[8];
            end
            default: begin
                stepCnt[15:8] = c[15:8];
                stepCnt[7:0] = c8[7:0];
                stepCnt[16] = c8[8];
            end
        endcase
    endfunction : stepCnt

    logic [16:0] stepA, stepB;
    logic [8:0] stepAH;
    assign stepA = stepCnt(modeA, cntA_r);
    assign stepB = stepCnt(modeB, cntB_r);
    assign stepAH = 9'(cntA_r[15:8]) + 9'd1;

    logic splitA, ovfA, ovfB;
    assign splitA = (modeA == DCTM_MODESPLIT);
    assign ovfA = enA & stepA[16];
    // In split mode timer B flag belongs to the high byte of A
    assign ovfB = splitA ? (enAH & stepAH[8]) : (enB & stepB[16]);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic wrEn, rdEn;
    logic hitAL, hitAH, hitBL, hitBH, hitCtrl, hitMode, hitClk;
    logic hitExt, hitIrqEn, hitIrqClr, hitAny;
    assign wrEn = psel & penable & pwrite & pready_r;
    assign rdEn = psel & penable & ~pwrite & ~pready_r;
    assign hitAL = (paddr == `DCTM_OFS_A_LOW);
    assign hitAH = (paddr == `DCTM_OFS_A_HIGH);
    assign hitBL = (paddr == `DCTM_OFS_B_LOW);
    assign hitBH = (paddr == `DCTM_OFS_B_HIGH);
    assign hitCtrl = (paddr == `DCTM_OFS_CTRL);
    assign hitMode = (paddr == `DCTM_OFS_MODE);
    assign hitClk = (paddr == `DCTM_OFS_CLKSEL);
    assign hitExt = (paddr == `DCTM_OFS_EXTCFG);
    assign hitIrqEn = (paddr == `DCTM_OFS_IRQEN);
    assign hitIrqClr = (paddr == `DCTM_OFS_IRQCLR);
    assign hitAny = hitAL | hitAH | hitBL | hitBH | hitCtrl | hitMode
                  | hitClk | hitExt | hitIrqEn | hitIrqClr;

    logic [7:0] rdByte;
    assign rdByte = hitAL ? cntA_r[7:0] :
                    hitAH ? cntA_r[15:8] :
                    hitBL ? cntB_r[7:0] :
                    hitBH ? cntB_r[15:8] :
                    hitCtrl ? ctrl_r :
                    hitMode ? modeReg_r :
                    hitClk ? {3'b000, clkSel_r[4:0]} :
                    hitExt ? extCfg_r :
                    hitIrqEn ? {6'b000000, irqEn_r[1:0]} :
                    8'h00;

    // ----------------------------------------------------------------
    // Counters: a software byte write wins over counting
    // ----------------------------------------------------------------
    dctm_count_t cntA_nxt, cntB_nxt;
    always_comb begin
        cntA_nxt = cntA_r;
        if (splitA && enAH) begin
            cntA_nxt[15:8] = stepAH[7:0];
        end
        if (enA) begin
            cntA_nxt[7:0] = stepA[7:0];
            if (!splitA) begin
                cntA_nxt[15:8] = stepA[15:8];
            end
        end
        if (wrEn && hitAL) begin
            cntA_nxt[7:0] = pwdata[7:0];
        end
        if (wrEn && hitAH) begin
            cntA_nxt[15:8] = pwdata[7:0];
        end
        cntB_nxt = enB ? stepB[15:0] : cntB_r;
        if (wrEn && hitBL) begin
            cntB_nxt[7:0] = pwdata[7:0];
        end
        if (wrEn && hitBH) begin
            cntB_nxt[15:8] = pwdata[7:0];
        end
    end

    // Run bit is plain storage: counters never reset on start
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cntA_r <= 16'h0000;
            cntB_r <= 16'h0000;
        end else begin
            cntA_r <= cntA_nxt;
            cntB_r <= cntB_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Control, flags and configuration
    // ----------------------------------------------------------------
    logic [7:0] ctrl_nxt;
    logic clrA, clrB;
    assign clrA = irqAckA | (wrEn & hitIrqClr & pwdata[`DCTM_IRQ_A]);
    assign clrB = irqAckB | (wrEn & hitIrqClr & pwdata[`DCTM_IRQ_B]);
    always_comb begin
        ctrl_nxt = (wrEn && hitCtrl) ? pwdata[7:0] : ctrl_r;
        if (clrA) begin
            ctrl_nxt[`DCTM_CTRL_OVF_A] = 1'b0;
        end
        if (clrB) begin
            ctrl_nxt[`DCTM_CTRL_OVF_B] = 1'b0;
        end
        // Hardware set wins over any clear in the same cycle
        if (ovfA) begin
            ctrl_nxt[`DCTM_CTRL_OVF_A] = 1'b1;
        end
        if (ovfB) begin
            ctrl_nxt[`DCTM_CTRL_OVF_B] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r <= `DCTM_RST_BYTE;
            modeReg_r <= `DCTM_RST_BYTE;
            clkSel_r <= `DCTM_RST_BYTE;
            extCfg_r <= `DCTM_RST_BYTE;
            irqEn_r <= `DCTM_RST_BYTE;
        end else begin
            ctrl_r <= ctrl_nxt;
            if (wrEn && hitMode) begin
                modeReg_r <= pwdata[7:0];
            end
            if (wrEn && hitClk) begin
                clkSel_r <= pwdata[7:0];
            end
            if (wrEn && hitExt) begin
                extCfg_r <= pwdata[7:0];
            end
            if (wrEn && hitIrqEn) begin
                irqEn_r <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // APB answer and interrupt output
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            irq_r <= 1'b0;
        end else begin
            pready_r <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~hitAny;
            prdata_r <= rdEn ? {24'h000000, rdByte} : 32'h00000000;
            irq_r <= (ctrl_nxt[`DCTM_CTRL_OVF_A] & irqEn_r[`DCTM_IRQ_A])
                   | (ctrl_nxt[`DCTM_CTRL_OVF_B]
                      & irqEn_r[`DCTM_IRQ_B]);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irqOut = irq_r;
endmodule : dctm_top

/* dctm_top_properties.sv */
// Port checker for dctm_top, attached by the bind at the foot.
// Assumes one clock and the two-cycle APB access of the block.
`timescale 1ns/10ps
module dctm_top_properties (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timerACountPin,
    input wire logic timerBCountPin,
    input wire logic extGateInput,
    input wire logic irqAckA,
    input wire logic irqAckB,
    input wire logic irqOut
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (reset);
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_READY_LAT: assert property (
        psel && penable && !pready |=> pready)
        else $error("access not answered next cycle");
    AST_READY_CAUSE: assert property (
        pready |-> $past(psel && penable))
        else $error("pready without access");
    AST_ERR_DECODE: assert property (
        pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h024))
        else $error("slave error decode wrong");
    AST_ERR_ONLY: assert property (pslverr |-> pready)
        else $error("slave error outside answer");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero when idle");
    AST_RDATA_UPPER: assert property (prdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    AST_CLR_READ: assert property (
        pready && !pwrite && paddr == 12'h024 |-> prdata == 32'h0)
        else $error("clear register read not zero");
    AST_RESET_QUIET: assert property (
        $fell(reset) |-> !pready && !irqOut && !pslverr)
        else $error("outputs active after reset");
    COV_ERR: cover property (pslverr);
    COV_IRQ: cover property ($rose(irqOut));
    COV_WRITE: cover property (pready && pwrite);
endmodule : dctm_top_properties

bind dctm_top dctm_top_properties u_props (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerACountPin(timerACountPin),
    .timerBCountPin(timerBCountPin), .extGateInput(extGateInput),
    .irqAckA(irqAckA), .irqAckB(irqAckB), .irqOut(irqOut));

/* dctm_pin_model.sv */
// Far-side model: count pins and gating level.
// Assumes tasks are entered just after a rising edge of core_clk.
`timescale 1ns/10ps
module dctm_pin_model (
    input wire logic core_clk,
    output logic pinA,
    output logic pinB,
    output logic gateLvl
);
    initial begin
        pinA = 1'b1;
        pinB = 1'b1;
        gateLvl = 1'b0;
    end
    // Never under two clocks per level, else edges may be missed
    task automatic pulse(input logic selB, input int n, input int hold);
        int h;
        h = (hold < 2) ? 2 : hold;
        for (int i = 0; i < n; i++) begin
            if (selB) pinB <= 1'b0;
            else pinA <= 1'b0;
            repeat (h) @(posedge core_clk);
            if (selB) pinB <= 1'b1;
            else pinA <= 1'b1;
            repeat (h) @(posedge core_clk);
        end
    endtask : pulse
    task automatic setGate(input logic v);
        gateLvl <= v;
    endtask : setGate
endmodule : dctm_pin_model

/* dctm_top_tb.sv */
// Self-checking bench for dctm_top, APB master plus pin model.
// Assumes the offsets of dctm_defs.svh and the pin model tasks.
`timescale 1ns/10ps
`include "dctm_defs.svh"
module dctm_top_tb;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic irqOut, irqAckA, irqAckB, pinA, pinB, gateLvl, errSeen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [12:0] va, vb;
    int n_errors, check_count, cycles;
    localparam int WAITS [5] = '{20, 48, 96, 192, 0};
    localparam int EXPS [5] = '{20, 12, 8, 4, 6};
    localparam logic [7:0] SELS [5] = '{8'h08, 8'h01, 8'h00, 8'h02, 8'h03};

    dctm_top DUT (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerACountPin(pinA),
        .timerBCountPin(pinB), .extGateInput(gateLvl),
        .irqAckA(irqAckA), .irqAckB(irqAckB), .irqOut(irqOut));
    dctm_pin_model pm (.core_clk(core_clk), .pinA(pinA), .pinB(pinB),
        .gateLvl(gateLvl));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdata = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 8'h00);
    endtask : rd
    // Only while stopped or idle: high then low read could tear
    task automatic get13(input logic b, output logic [12:0] v);
        rd(b ? `DCTM_OFS_B_HIGH : `DCTM_OFS_A_HIGH);
        v[12:5] = rdata[7:0];
        rd(b ? `DCTM_OFS_B_LOW : `DCTM_OFS_A_LOW);
        v[4:0] = rdata[4:0];
    endtask : get13
    task automatic clr();
        for (int a = 0; a < 16; a += 4) wr(12'(a), 8'h00);
    endtask : clr
    task automatic measure(input logic [7:0] sel, input int w,
                           input int n, output int c);
        clr();
        wr(`DCTM_OFS_CLKSEL, sel);
        wr(`DCTM_OFS_CTRL, 8'h10);
        repeat (w) @(posedge core_clk);
        pm.pulse(1'b1, n, 3);
        wr(`DCTM_OFS_CTRL, 8'h00);
        get13(1'b0, va);
        c = int'(va);
    endtask : measure
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        for (int a = 0; a <= 36; a += 4) begin
            rd(12'(a));
            check("reset value", rdata, 32'h0);
        end
        rd(12'h028);
        check("unmapped err", 32'(errSeen), 32'h1);
        check("unmapped data", rdata, 32'h0);
    endtask : test_reset
    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            wr(`DCTM_OFS_MODE, 8'(m * 16 + 3 - m));
            rd(`DCTM_OFS_MODE);
            check("mode fields", rdata, 32'(m * 16 + 3 - m));
        end
    endtask : test_modes
    task automatic test_ext();
        clr();
        wr(`DCTM_OFS_A_LOW, 8'h03);
        wr(`DCTM_OFS_MODE, 8'h04);
        wr(`DCTM_OFS_CTRL, 8'h10);
        pm.pulse(1'b0, 5, 2);
        repeat (4) @(posedge core_clk);
        wr(`DCTM_OFS_CTRL, 8'h00);
        pm.pulse(1'b0, 3, 2);
        repeat (4) @(posedge core_clk);
        get13(1'b0, va);
        check("pin count a", 32'(va), 32'h8);
        get13(1'b1, vb);
        check("pin count b", 32'(vb), 32'h0);
    endtask : test_ext
    task automatic test_ovf();
        wr(`DCTM_OFS_A_HIGH, 8'hFF);
        wr(`DCTM_OFS_A_LOW, 8'hFE);
        wr(`DCTM_OFS_CTRL, 8'h10);
        pm.pulse(1'b0, 2, 3);
        repeat (4) @(posedge core_clk);
        rd(`DCTM_OFS_CTRL);
        check("flag set", rdata, 32'h30);
        get13(1'b0, va);
        check("wrapped", 32'(va), 32'h0);
        check("irq masked", 32'(irqOut), 32'h0);
        wr(`DCTM_OFS_IRQEN, 8'h01);
        repeat (2) @(posedge core_clk);
        check("irq raised", 32'(irqOut), 32'h1);
        irqAckA <= 1'b1;
        @(posedge core_clk);
        irqAckA <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("irq acked", 32'(irqOut), 32'h0);
        rd(`DCTM_OFS_CTRL);
        check("flag acked", rdata, 32'h10);
        wr(`DCTM_OFS_CTRL, 8'h20);
        repeat (2) @(posedge core_clk);
        check("irq soft", 32'(irqOut), 32'h1);
        wr(`DCTM_OFS_IRQCLR, 8'h01);
        repeat (2) @(posedge core_clk);
        check("irq cleared", 32'(irqOut), 32'h0);
        wr(`DCTM_OFS_IRQEN, 8'h00);
    endtask : test_ovf
    // Prescaler phase is free, so divided sources get one count slack
    task automatic test_clk();
        int c0, c1, d, tol;
        logic ok;
        wr(`DCTM_OFS_MODE, 8'h00);
        for (int i = 0; i < 5; i++) begin
            measure(SELS[i], 0, 0, c0);
            measure(SELS[i], WAITS[i], (i == 4) ? 6 : 0, c1);
            d = c1 - c0;
            tol = (i == 0 || i == 4) ? 0 : 1;
            ok = (d >= EXPS[i] - tol) && (d <= EXPS[i] + tol);
            check("clock source", 32'(ok), 32'h1);
        end
    endtask : test_clk
    task automatic test_gate();
        wr(`DCTM_OFS_MODE, 8'h88);
        wr(`DCTM_OFS_CLKSEL, 8'h18);
        wr(`DCTM_OFS_EXTCFG, 8'h08);
        for (int g = 1; g >= 0; g--) begin
            pm.setGate(g[0]);
            clr();
            wr(`DCTM_OFS_CTRL, 8'h50);
            repeat (10) @(posedge core_clk);
            wr(`DCTM_OFS_CTRL, 8'h00);
            get13(1'b0, va);
            get13(1'b1, vb);
            check("gate a", 32'(g ? va >= 10 : va == 0), 32'h1);
            check("gate b", 32'(g ? vb == 0 : vb >= 10), 32'h1);
        end
    endtask : test_gate
    task automatic test_b16();
        clr();
        wr(`DCTM_OFS_MODE, 8'h50);
        wr(`DCTM_OFS_B_HIGH, 8'hFF);
        wr(`DCTM_OFS_B_LOW, 8'hFF);
        wr(`DCTM_OFS_IRQEN, 8'h02);
        wr(`DCTM_OFS_CTRL, 8'h40);
        pm.pulse(1'b1, 1, 3);
        repeat (4) @(posedge core_clk);
        rd(`DCTM_OFS_CTRL);
        check("flag b", rdata, 32'hC0);
        check("irq b", 32'(irqOut), 32'h1);
        rd(`DCTM_OFS_B_HIGH);
        check("wrap16 b", rdata, 32'h0);
        irqAckB <= 1'b1;
        @(posedge core_clk);
        irqAckB <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("irq b acked", 32'(irqOut), 32'h0);
    endtask : test_b16
    task automatic test_reload();
        wr(`DCTM_OFS_CTRL, 8'h00);
        wr(`DCTM_OFS_MODE, 8'h06);
        wr(`DCTM_OFS_A_HIGH, 8'h80);
        wr(`DCTM_OFS_A_LOW, 8'hFF);
        wr(`DCTM_OFS_CTRL, 8'h10);
        pm.pulse(1'b0, 2, 3);
        repeat (4) @(posedge core_clk);
        rd(`DCTM_OFS_A_LOW);
        check("reload a", rdata, 32'h81);
        rd(`DCTM_OFS_CTRL);
        check("flag a8", rdata, 32'h30);
    endtask : test_reload
    // High byte runs on system clock, so only its flag is exact
    task automatic test_split();
        wr(`DCTM_OFS_CTRL, 8'h00);
        wr(`DCTM_OFS_MODE, 8'h07);
        wr(`DCTM_OFS_A_HIGH, 8'hFF);
        wr(`DCTM_OFS_A_LOW, 8'h10);
        wr(`DCTM_OFS_CTRL, 8'h50);
        pm.pulse(1'b0, 1, 3);
        rd(`DCTM_OFS_CTRL);
        check("split flag b", rdata, 32'hD0);
        wr(`DCTM_OFS_CTRL, 8'h00);
        rd(`DCTM_OFS_A_LOW);
        check("split low a", rdata, 32'h11);
        rd(`DCTM_OFS_B_LOW);
        check("split b halted", rdata, 32'h0);
    endtask : test_split

    initial begin
        reset <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        irqAckA <= 1'b0;
        irqAckB <= 1'b0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        check("irq reset", 32'(irqOut), 32'h0);
        test_reset();
        test_modes();
        test_ext();
        test_ovf();
        test_clk();
        test_gate();
        test_b16();
        test_reload();
        test_split();
        close_out();
    end
endmodule : dctm_top_tb
